// [include/gmii_pcs_pkg.sv]
// Shared constants and types of the GMII PCS port
package gmii_pcs_pkg;
  // Register byte offsets
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h00;
  localparam logic [7:0] IRQ_CLR_ADDR  = 8'h04;
  localparam logic [7:0] IRQ_EN_ADDR   = 8'h08;
  localparam logic [7:0] CTRL_ADDR     = 8'h0C;
  localparam logic [7:0] AEMPTY_ADDR   = 8'h10;
  localparam logic [7:0] AFULL_ADDR    = 8'h14;
  localparam logic [7:0] LEVEL_ADDR    = 8'h18;
  // Control register fields and reset value
  localparam int         CTRL_TX_EN = 0;
  localparam int         CTRL_RX_EN = 1;
  localparam logic [1:0] CTRL_RST   = 2'h3;
  // Event bit positions
  localparam int EV_TX_OVF = 0;
  localparam int EV_RX_OVF = 1;
  localparam int EV_RX_UNF = 2;
  localparam int EV_TX_ERR = 3;
  localparam int EV_W      = 4;
  // Fifo status bit positions
  localparam int STAT_EMPTY  = 3;
  localparam int STAT_AEMPTY = 2;
  localparam int STAT_FULL   = 1;
  localparam int STAT_AFULL  = 0;
  // Threshold reset values
  localparam logic [3:0] AEMPTY_RST = 4'h2;
  localparam logic [3:0] AFULL_RST  = 4'h6;
  // Code characters on the link
  localparam logic [7:0] CHAR_START = 8'hFB;
  localparam logic [7:0] CHAR_TERM  = 8'hFD;
  localparam logic [7:0] CHAR_CARR  = 8'hF7;
  localparam logic [7:0] CHAR_VERR  = 8'hFE;
  // Receive data values
  localparam logic [7:0] RXD_ERR    = 8'h0E;
  localparam logic [7:0] RXD_NOSYNC = 8'hFF;
  localparam logic [7:0] RXD_RESET  = 8'h00;
  localparam logic [7:0] RXD_IDLE   = 8'h00;
  // Transmit framing states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LEAD = 2'b01,
    TX_DATA = 2'b10,
    TX_TERM = 2'b11
  } tx_state_type;
endpackage

// [hdl/gmii_pcs_port.sv]
// GMII PCS port: framing, fifos, APB registers, interrupt
//
// Summary of operation
// - Receive valid marks data and start character
// - Receive error forces data to 0x0E
// - Data low in reset, high until sync
// - Transmit reset clears transmit logic, fifo
// - Start character inserted during enable lead
// - Enable fall inserts T then R
// - Transmit error substitutes /V/ symbol
// - Transmit data sampled at clock falling edge
// - Transmit fifo status: empty, aempty, full, afull
// - Receive fifo status, same bit layout
// - Receive reset clears receive logic, fifo
`timescale 1ns/1ps
module gmii_pcs_port #(
  parameter int PTR_W    = 3,
  parameter int LINK_DIV = 4
) (
  // Clock and reset
  input  wire logic       CLOCK_I,
  input  wire logic       RESET_I,
  // APB slave
  input  wire logic       PSEL_I,
  input  wire logic       PENABLE_I,
  input  wire logic       PWRITE_I,
  input  wire logic [7:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]     PRDATA_O,
  output logic            PREADY_O,
  output logic            PSLVERR_O,
  output logic            IRQ_O,
  // GMII transmit from the MAC
  input  wire logic       TX_CLK_I,
  input  wire logic       TX_RESET_N_I,
  input  wire logic       TX_EN_I,
  input  wire logic       TX_ER_I,
  input  wire logic [7:0] TX_DATA_I,
  output logic [3:0]      TX_FIFO_STATUS_O,
  // GMII receive to the MAC
  input  wire logic       RX_CLK_I,
  input  wire logic       RX_RESET_N_I,
  output logic [7:0]      RX_DATA_O,
  output logic            RX_DV_O,
  output logic            RX_ER_O,
  output logic [3:0]      RX_FIFO_STATUS_O,
  // Serial link side
  output logic [7:0]      LINK_TX_DATA_O,
  output logic            LINK_TX_CTRL_O,
  output logic            LINK_TX_VALID_O,
  input  wire logic [7:0] LINK_RX_DATA_I,
  input  wire logic       LINK_RX_CTRL_I,
  input  wire logic       LINK_RX_VALID_I,
  input  wire logic       LINK_SYNC_I
);
  localparam int         CW     = PTR_W + 1;
  localparam logic [PTR_W:0] DEPTH_C = {1'b1, {PTR_W{1'b0}}};
  localparam logic [PTR_W:0] ZERO_C  = '0;

  // Synchroniser stages for pin inputs
  logic [13:0] pin_in;
  logic [13:0] s1_ff;
  logic [13:0] s2_ff;
  logic        txc3_ff;   // Delayed tx clock level
  logic        rxc3_ff;   // Delayed rx clock level
  // Decoded synchronised inputs
  logic        tx_fall;
  logic        rx_rise;
  logic        tx_rst;
  logic        rx_rst;
  logic        tx_en_s;
  logic        tx_er_s;
  logic [7:0]  tx_d_s;

  assign pin_in = {TX_CLK_I, TX_RESET_N_I, TX_EN_I, TX_ER_I,
                   TX_DATA_I, RX_CLK_I, RX_RESET_N_I};

  // Two-stage sync, plus one stage for edge finding
  always_ff @(posedge CLOCK_I) begin
    s1_ff   <= pin_in;
    s2_ff   <= s1_ff;
    txc3_ff <= s2_ff[13];
    rxc3_ff <= s2_ff[1];
  end

  // MAC launches on rising edge; mid-period fall sees settled data
  assign tx_fall = ~s2_ff[13] & txc3_ff;
  assign rx_rise = s2_ff[1] & ~rxc3_ff;
  assign tx_rst  = RESET_I | ~s2_ff[12];
  assign rx_rst  = RESET_I | ~s2_ff[0];
  assign tx_en_s = s2_ff[11];
  assign tx_er_s = s2_ff[10];
  assign tx_d_s  = s2_ff[9:2];

  // Link pacing divider
  logic [7:0] div_ff;
  logic [7:0] nxt_div;
  logic       div_tick;

  // Divider next value
  always_comb begin
    nxt_div = div_ff + 8'h01;
    if (RESET_I || div_ff == 8'(LINK_DIV - 1)) begin
      nxt_div = 8'h00;
    end
  end
  assign div_tick = (div_ff == 8'h00);

  // Divider register
  always_ff @(posedge CLOCK_I) begin
    div_ff <= nxt_div;
  end

  // Register file state
  logic [gmii_pcs_pkg::EV_W-1:0] irq_st_ff;
  logic [gmii_pcs_pkg::EV_W-1:0] nxt_irq_st;
  logic [gmii_pcs_pkg::EV_W-1:0] irq_en_ff;
  logic [gmii_pcs_pkg::EV_W-1:0] nxt_irq_en;
  logic [1:0]      ctrl_ff;
  logic [1:0]      nxt_ctrl;
  logic [PTR_W:0]  ae_ff;       // Almost-empty level
  logic [PTR_W:0]  nxt_ae;
  logic [PTR_W:0]  af_ff;       // Almost-full level
  logic [PTR_W:0]  nxt_af;
  logic [gmii_pcs_pkg::EV_W-1:0] events;  // One-cycle event pulses
  // APB answer state
  logic [31:0]     nxt_prdata;
  logic            nxt_pready;
  logic            nxt_pslverr;
  logic            nxt_irq;

  // Transmit state
  gmii_pcs_pkg::tx_state_type tx_st_ff;
  gmii_pcs_pkg::tx_state_type nxt_tx_st;
  logic [8:0]      tx_mem [2**PTR_W];  // {ctrl, byte}
  logic [PTR_W-1:0] tx_wp_ff;
  logic [PTR_W-1:0] nxt_tx_wp;
  logic [PTR_W-1:0] tx_rp_ff;
  logic [PTR_W-1:0] nxt_tx_rp;
  logic [PTR_W:0]  tx_cnt_ff;
  logic [PTR_W:0]  nxt_tx_cnt;
  logic            tx_push;
  logic [8:0]      tx_pdat;
  logic            tx_wr;
  logic            tx_pop;
  logic            tx_full;
  logic [8:0]      nxt_ltx;
  logic            nxt_ltx_valid;
  logic [3:0]      nxt_tx_stat;

  // Receive state
  logic [8:0]      rx_mem [2**PTR_W];
  logic [PTR_W-1:0] rx_wp_ff;
  logic [PTR_W-1:0] nxt_rx_wp;
  logic [PTR_W-1:0] rx_rp_ff;
  logic [PTR_W-1:0] nxt_rx_rp;
  logic [PTR_W:0]  rx_cnt_ff;
  logic [PTR_W:0]  nxt_rx_cnt;
  logic            rx_wr;
  logic            rx_pop;
  logic [8:0]      rx_head;
  logic [7:0]      nxt_rxd;
  logic            nxt_rxdv;
  logic            nxt_rxer;
  logic [3:0]      nxt_rx_stat;

  // Fill-level status word from count and thresholds
  function automatic logic [3:0] fifo_stat(input logic [PTR_W:0] cnt,
                                           input logic [PTR_W:0] ae,
                                           input logic [PTR_W:0] af);
    logic [3:0] s;
    s = 4'h0;
    s[gmii_pcs_pkg::STAT_EMPTY]  = (cnt == ZERO_C);
    s[gmii_pcs_pkg::STAT_AEMPTY] = (cnt <= ae);
    s[gmii_pcs_pkg::STAT_FULL]   = (cnt == DEPTH_C);
    s[gmii_pcs_pkg::STAT_AFULL]  = (cnt >= af);
    return s;
  endfunction

  // Transmit framing, fifo write and link drain
  always_comb begin
    nxt_tx_st = tx_st_ff;
    tx_push   = 1'b0;
    tx_pdat   = 9'h000;
    if (tx_fall) begin
      unique case (tx_st_ff)
        gmii_pcs_pkg::TX_IDLE: begin
          // First lead cycle carries the start character
          if (tx_en_s) begin
            tx_push   = 1'b1;
            tx_pdat   = {1'b1, gmii_pcs_pkg::CHAR_START};
            nxt_tx_st = gmii_pcs_pkg::TX_LEAD;
          end
        end
        gmii_pcs_pkg::TX_LEAD: begin
          // Second lead cycle: data not yet valid
          nxt_tx_st = gmii_pcs_pkg::TX_DATA;
        end
        gmii_pcs_pkg::TX_DATA: begin
          if (tx_en_s) begin
            tx_push = 1'b1;
            // Error symbol replaces the byte
            tx_pdat = tx_er_s ? {1'b1, gmii_pcs_pkg::CHAR_VERR}
                              : {1'b0, tx_d_s};
          end else begin
            // Enable fell: terminate
            tx_push   = 1'b1;
            tx_pdat   = {1'b1, gmii_pcs_pkg::CHAR_TERM};
            nxt_tx_st = gmii_pcs_pkg::TX_TERM;
          end
        end
        gmii_pcs_pkg::TX_TERM: begin
          // Carrier-extend follows terminate
          tx_push   = 1'b1;
          tx_pdat   = {1'b1, gmii_pcs_pkg::CHAR_CARR};
          nxt_tx_st = gmii_pcs_pkg::TX_IDLE;
        end
      endcase
    end
    tx_full = (tx_cnt_ff == DEPTH_C);
    tx_wr   = tx_push & ~tx_full;
    tx_pop  = div_tick & ctrl_ff[gmii_pcs_pkg::CTRL_TX_EN] & (tx_cnt_ff != ZERO_C);
    nxt_tx_wp  = tx_wr ? tx_wp_ff + 1'b1 : tx_wp_ff;
    nxt_tx_rp  = tx_pop ? tx_rp_ff + 1'b1 : tx_rp_ff;
    nxt_tx_cnt = tx_cnt_ff;
    if (tx_wr && !tx_pop) begin
      nxt_tx_cnt = tx_cnt_ff + 1'b1;
    end else if (tx_pop && !tx_wr) begin
      nxt_tx_cnt = tx_cnt_ff - 1'b1;
    end
    nxt_ltx_valid = tx_pop;
    nxt_ltx = tx_pop ? tx_mem[tx_rp_ff] : {LINK_TX_CTRL_O, LINK_TX_DATA_O};
    // Transmit reset clears framing and fifo
    if (tx_rst) begin
      nxt_tx_st     = gmii_pcs_pkg::TX_IDLE;
      nxt_tx_wp     = '0;
      nxt_tx_rp     = '0;
      nxt_tx_cnt    = '0;
      nxt_ltx_valid = 1'b0;
      nxt_ltx       = 9'h000;
    end
    nxt_tx_stat = fifo_stat(nxt_tx_cnt, ae_ff, af_ff);
  end

  // Transmit registers and fifo storage
  always_ff @(posedge CLOCK_I) begin
    tx_st_ff         <= nxt_tx_st;
    tx_wp_ff         <= nxt_tx_wp;
    tx_rp_ff         <= nxt_tx_rp;
    tx_cnt_ff        <= nxt_tx_cnt;
    LINK_TX_VALID_O  <= nxt_ltx_valid;
    LINK_TX_CTRL_O   <= nxt_ltx[8];
    LINK_TX_DATA_O   <= nxt_ltx[7:0];
    TX_FIFO_STATUS_O <= nxt_tx_stat;
    if (tx_wr) begin
      tx_mem[tx_wp_ff] <= tx_pdat;
    end
  end

  // Receive fifo fill from link and GMII decode
  always_comb begin
    rx_wr   = LINK_RX_VALID_I & ctrl_ff[gmii_pcs_pkg::CTRL_RX_EN] & (rx_cnt_ff != DEPTH_C);
    rx_head = rx_mem[rx_rp_ff];
    rx_pop  = 1'b0;
    nxt_rxd  = RX_DATA_O;
    nxt_rxdv = RX_DV_O;
    nxt_rxer = RX_ER_O;
    // Data, valid and error outputs move only on receive clock edges and in receive reset
    if (rx_rise) begin
      if (!LINK_SYNC_I) begin
        // No frame sync: all data bits high
        nxt_rxd  = gmii_pcs_pkg::RXD_NOSYNC;
        nxt_rxdv = 1'b0;
        nxt_rxer = 1'b0;
      end else if (rx_cnt_ff == ZERO_C) begin
        nxt_rxd  = gmii_pcs_pkg::RXD_IDLE;
        nxt_rxdv = 1'b0;
        nxt_rxer = 1'b0;
      end else begin
        rx_pop   = 1'b1;
        nxt_rxer = 1'b0;
        nxt_rxd  = rx_head[7:0];
        nxt_rxdv = 1'b1;
        if (rx_head[8] && rx_head[7:0] == gmii_pcs_pkg::CHAR_VERR) begin
          // Error symbol: fixed data, keep packet open
          nxt_rxer = 1'b1;
          nxt_rxd  = gmii_pcs_pkg::RXD_ERR;
          nxt_rxdv = RX_DV_O;
        end else if (rx_head[8] && rx_head[7:0] != gmii_pcs_pkg::CHAR_START) begin
          // Terminate, extend, idle codes end valid
          nxt_rxd  = gmii_pcs_pkg::RXD_IDLE;
          nxt_rxdv = 1'b0;
        end
      end
    end
    nxt_rx_wp  = rx_wr ? rx_wp_ff + 1'b1 : rx_wp_ff;
    nxt_rx_rp  = rx_pop ? rx_rp_ff + 1'b1 : rx_rp_ff;
    nxt_rx_cnt = rx_cnt_ff;
    if (rx_wr && !rx_pop) begin
      nxt_rx_cnt = rx_cnt_ff + 1'b1;
    end else if (rx_pop && !rx_wr) begin
      nxt_rx_cnt = rx_cnt_ff - 1'b1;
    end
    // Receive reset: outputs low, fifo cleared
    if (rx_rst) begin
      nxt_rxd    = gmii_pcs_pkg::RXD_RESET;
      nxt_rxdv   = 1'b0;
      nxt_rxer   = 1'b0;
      nxt_rx_wp  = '0;
      nxt_rx_rp  = '0;
      nxt_rx_cnt = '0;
    end
    nxt_rx_stat = fifo_stat(nxt_rx_cnt, ae_ff, af_ff);
  end

  // Receive registers and fifo storage
  always_ff @(posedge CLOCK_I) begin
    rx_wp_ff         <= nxt_rx_wp;
    rx_rp_ff         <= nxt_rx_rp;
    rx_cnt_ff        <= nxt_rx_cnt;
    RX_DATA_O        <= nxt_rxd;
    RX_DV_O          <= nxt_rxdv;
    RX_ER_O          <= nxt_rxer;
    RX_FIFO_STATUS_O <= nxt_rx_stat;
    if (rx_wr) begin
      rx_mem[rx_wp_ff] <= {LINK_RX_CTRL_I, LINK_RX_DATA_I};
    end
  end

  // Event pulses into the sticky status
  always_comb begin
    events            = '0;
    events[gmii_pcs_pkg::EV_TX_OVF] = tx_push & tx_full & ~tx_rst;
    events[gmii_pcs_pkg::EV_RX_OVF] = LINK_RX_VALID_I & ctrl_ff[gmii_pcs_pkg::CTRL_RX_EN]
                                      & ~rx_wr & ~rx_rst;
    events[gmii_pcs_pkg::EV_RX_UNF] = rx_rise & LINK_SYNC_I & RX_DV_O & ~rx_rst
                                      & (rx_cnt_ff == ZERO_C);
    events[gmii_pcs_pkg::EV_TX_ERR] = tx_fall & ~tx_rst & (tx_st_ff == gmii_pcs_pkg::TX_DATA)
                                      & tx_en_s & tx_er_s;
  end

  // APB decode, register writes and read data
  always_comb begin
    logic setup;
    logic acc;
    logic [gmii_pcs_pkg::EV_W-1:0] clr;
    setup       = PSEL_I & ~PENABLE_I;
    acc         = PSEL_I & PENABLE_I & PREADY_O;
    clr         = '0;
    nxt_irq_en  = irq_en_ff;
    nxt_ctrl    = ctrl_ff;
    nxt_ae      = ae_ff;
    nxt_af      = af_ff;
    nxt_pready  = setup;
    nxt_prdata  = PRDATA_O;
    nxt_pslverr = acc ? 1'b0 : PSLVERR_O;
    // Read data and error latched at setup
    if (setup) begin
      nxt_pslverr = 1'b0;
      nxt_prdata  = 32'h0000_0000;
      unique case (PADDR_I)
        gmii_pcs_pkg::IRQ_STAT_ADDR: nxt_prdata = 32'(irq_st_ff);
        gmii_pcs_pkg::IRQ_CLR_ADDR:  nxt_prdata = 32'h0000_0000;
        gmii_pcs_pkg::IRQ_EN_ADDR:   nxt_prdata = 32'(irq_en_ff);
        gmii_pcs_pkg::CTRL_ADDR:     nxt_prdata = 32'(ctrl_ff);
        gmii_pcs_pkg::AEMPTY_ADDR:   nxt_prdata = 32'(ae_ff);
        gmii_pcs_pkg::AFULL_ADDR:    nxt_prdata = 32'(af_ff);
        gmii_pcs_pkg::LEVEL_ADDR:    nxt_prdata = {8'h00, 8'(rx_cnt_ff), 8'h00, 8'(tx_cnt_ff)};
        default:       nxt_pslverr = 1'b1;
      endcase
    end
    // Writes take effect at the completing edge
    if (acc && PWRITE_I) begin
      unique case (PADDR_I)
        gmii_pcs_pkg::IRQ_CLR_ADDR: clr        = PWDATA_I[gmii_pcs_pkg::EV_W-1:0];
        gmii_pcs_pkg::IRQ_EN_ADDR:  nxt_irq_en = PWDATA_I[gmii_pcs_pkg::EV_W-1:0];
        gmii_pcs_pkg::CTRL_ADDR:    nxt_ctrl   = PWDATA_I[1:0];
        gmii_pcs_pkg::AEMPTY_ADDR:  nxt_ae     = PWDATA_I[PTR_W:0];
        gmii_pcs_pkg::AFULL_ADDR:   nxt_af     = PWDATA_I[PTR_W:0];
        default:      nxt_ctrl   = ctrl_ff;
      endcase
    end
    // New event wins over a clear
    nxt_irq_st = (irq_st_ff & ~clr) | events;
    nxt_irq    = |(irq_st_ff & irq_en_ff);
    if (RESET_I) begin
      nxt_irq_st  = '0;
      nxt_irq_en  = '0;
      nxt_ctrl    = gmii_pcs_pkg::CTRL_RST;
      nxt_ae      = CW'(gmii_pcs_pkg::AEMPTY_RST);
      nxt_af      = CW'(gmii_pcs_pkg::AFULL_RST);
      nxt_pready  = 1'b0;
      nxt_prdata  = 32'h0000_0000;
      nxt_pslverr = 1'b0;
      nxt_irq     = 1'b0;
    end
  end

  // Register file and APB answer registers
  always_ff @(posedge CLOCK_I) begin
    irq_st_ff <= nxt_irq_st;
    irq_en_ff <= nxt_irq_en;
    ctrl_ff   <= nxt_ctrl;
    ae_ff     <= nxt_ae;
    af_ff     <= nxt_af;
    PREADY_O  <= nxt_pready;
    PRDATA_O  <= nxt_prdata;
    PSLVERR_O <= nxt_pslverr;
    IRQ_O     <= nxt_irq;
  end

  // Checks on framing and receive output behaviour
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);

  // Enable seen first time at an idle fall
  sequence en_rise_s;
    tx_fall && !tx_rst && tx_st_ff == gmii_pcs_pkg::TX_IDLE && tx_en_s && !tx_full;
  endsequence
  // Enable seen low after data
  sequence en_fall_s;
    tx_fall && !tx_rst && tx_st_ff == gmii_pcs_pkg::TX_DATA && !tx_en_s && !tx_full;
  endsequence
  // Data byte with error flag
  sequence err_byte_s;
    tx_fall && !tx_rst && tx_st_ff == gmii_pcs_pkg::TX_DATA && tx_en_s && tx_er_s && !tx_full;
  endsequence

  a_tx_start_char: assert property (
    en_rise_s |=> tx_mem[$past(tx_wp_ff)] == {1'b1, gmii_pcs_pkg::CHAR_START}
                  && tx_st_ff == gmii_pcs_pkg::TX_LEAD)
    else $error("start character not written");
  a_tx_end_chars: assert property (
    en_fall_s |=> tx_mem[$past(tx_wp_ff)] == {1'b1, gmii_pcs_pkg::CHAR_TERM}
                  && tx_st_ff == gmii_pcs_pkg::TX_TERM)
    else $error("terminate character not written");
  a_tx_err_symbol: assert property (
    err_byte_s |=> tx_mem[$past(tx_wp_ff)] == {1'b1, gmii_pcs_pkg::CHAR_VERR})
    else $error("error symbol not written");
  a_tx_data_byte: assert property (
    tx_fall && !tx_rst && tx_st_ff == gmii_pcs_pkg::TX_DATA && tx_en_s && !tx_er_s && !tx_full
    |=> tx_mem[$past(tx_wp_ff)] == {1'b0, $past(tx_d_s)})
    else $error("transmit byte not stored");
  a_tx_reset_clear: assert property (
    tx_rst |=> tx_cnt_ff == ZERO_C && tx_st_ff == gmii_pcs_pkg::TX_IDLE && !LINK_TX_VALID_O)
    else $error("transmit reset left state");
  a_rx_err_data: assert property (
    RX_ER_O |-> RX_DATA_O == gmii_pcs_pkg::RXD_ERR)
    else $error("receive error with wrong data");
  a_rx_nosync_high: assert property (
    rx_rise && !rx_rst && !LINK_SYNC_I |=> RX_DATA_O == gmii_pcs_pkg::RXD_NOSYNC && !RX_DV_O)
    else $error("receive data not high before sync");
  a_rx_reset_low: assert property (
    !s2_ff[0] |=> RX_DATA_O == gmii_pcs_pkg::RXD_RESET && rx_cnt_ff == ZERO_C)
    else $error("receive reset not applied");
  a_rx_start_valid: assert property (
    rx_rise && !rx_rst && LINK_SYNC_I && rx_cnt_ff != ZERO_C
    && rx_head == {1'b1, gmii_pcs_pkg::CHAR_START} |=> RX_DV_O && !RX_ER_O)
    else $error("start character without valid");
  a_rx_edge_only: assert property (
    !rx_rise && !rx_rst |=> $stable(RX_DATA_O) && $stable(RX_DV_O))
    else $error("receive outputs moved off edge");
  a_tx_stat_empty: assert property (
    tx_cnt_ff == ZERO_C |-> TX_FIFO_STATUS_O[gmii_pcs_pkg::STAT_EMPTY]
                            && TX_FIFO_STATUS_O[gmii_pcs_pkg::STAT_AEMPTY]
                            && !TX_FIFO_STATUS_O[gmii_pcs_pkg::STAT_FULL])
    else $error("transmit empty flag wrong");
  a_rx_stat_full: assert property (
    rx_cnt_ff == DEPTH_C && !rx_pop && !rx_rst |=> RX_FIFO_STATUS_O[gmii_pcs_pkg::STAT_FULL])
    else $error("receive full flag wrong");
endmodule

// [tb/mac_model.sv]
// Behavioural Ethernet MAC on the far side of the GMII port
`timescale 1ns/1ps
module mac_model (
  // Interface clocks
  output logic            tx_clk_o,
  output logic            rx_clk_o,
  // Transmit stream
  output logic            tx_en_o,
  output logic            tx_er_o,
  output logic [7:0]      tx_data_o,
  // Transmit fifo level
  input  wire logic [3:0] tx_stat_i
);
  // Free running transmit clock, offset from the bench clock
  initial begin
    tx_en_o   = 1'b0;
    tx_er_o   = 1'b0;
    tx_data_o = 8'hA5;
    tx_clk_o  = 1'b0;
    #30;
    forever #400 tx_clk_o = ~tx_clk_o;
  end
  // Free running receive clock, another phase
  initial begin
    rx_clk_o = 1'b0;
    #270;
    forever #400 rx_clk_o = ~rx_clk_o;
  end
  // Two lead clocks, data bytes from 0x10, then enable drop
  task automatic send_frame(input int n, input int err_at);
    while (tx_stat_i[0] !== 1'b0) @(posedge tx_clk_o);
    @(posedge tx_clk_o);
    tx_en_o <= 1'b1;
    @(posedge tx_clk_o);
    for (int i = 0; i < n; i++) begin
      @(posedge tx_clk_o);
      tx_data_o <= 8'(8'h10 + i);
      tx_er_o   <= (i == err_at);
    end
    @(posedge tx_clk_o);
    tx_en_o   <= 1'b0;
    tx_er_o   <= 1'b0;
    // Released data shows a changed pattern
    tx_data_o <= ~tx_data_o;
    repeat (3) @(posedge tx_clk_o);
  endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench of the GMII PCS port
`timescale 1ns/1ps
module testbench;
  // Clock and resets
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        tx_rst_n = 1'b0;
  logic        rx_rst_n = 1'b0;
  // APB master
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  // GMII sides
  logic        tx_clk;
  logic        rx_clk;
  logic        tx_en;
  logic        tx_er;
  logic [7:0]  tx_data;
  logic [3:0]  tx_stat;
  logic [7:0]  rx_data;
  logic        rx_dv;
  logic        rx_er;
  logic [3:0]  rx_stat;
  // Link side
  logic [7:0]  ltx_data;
  logic        ltx_ctrl;
  logic        ltx_valid;
  logic [7:0]  lrx_data = 8'h00;
  logic        lrx_ctrl = 1'b0;
  logic        lrx_valid = 1'b0;
  logic        lsync = 1'b0;
  // Bookkeeping
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [8:0]  ltx_q [$];

  gmii_pcs_port #(.PTR_W(3), .LINK_DIV(4)) gmii_pcs_port_inst (
    .CLOCK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq), .TX_CLK_I(tx_clk),
    .TX_RESET_N_I(tx_rst_n), .TX_EN_I(tx_en), .TX_ER_I(tx_er), .TX_DATA_I(tx_data),
    .TX_FIFO_STATUS_O(tx_stat), .RX_CLK_I(rx_clk), .RX_RESET_N_I(rx_rst_n),
    .RX_DATA_O(rx_data), .RX_DV_O(rx_dv), .RX_ER_O(rx_er), .RX_FIFO_STATUS_O(rx_stat),
    .LINK_TX_DATA_O(ltx_data), .LINK_TX_CTRL_O(ltx_ctrl), .LINK_TX_VALID_O(ltx_valid),
    .LINK_RX_DATA_I(lrx_data), .LINK_RX_CTRL_I(lrx_ctrl), .LINK_RX_VALID_I(lrx_valid),
    .LINK_SYNC_I(lsync));

  mac_model mac_model_inst (
    .tx_clk_o(tx_clk), .rx_clk_o(rx_clk), .tx_en_o(tx_en), .tx_er_o(tx_er),
    .tx_data_o(tx_data), .tx_stat_i(tx_stat));

  // Bench clock, 100 ns period
  always #50 clk = ~clk;

  // Collect link transmit pulses
  always @(posedge clk) begin
    if (ltx_valid === 1'b1) ltx_q.push_back({ltx_ctrl, ltx_data});
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer, waits for ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // One link receive entry
  task automatic push(input logic [8:0] e);
    @(posedge clk);
    lrx_valid <= 1'b1;
    {lrx_ctrl, lrx_data} <= e;
    @(posedge clk);
    lrx_valid <= 1'b0;
    {lrx_ctrl, lrx_data} <= ~e;
  endtask

  // Reset values, unmapped access, empty fifos
  task automatic t_regs;
    logic [7:0]  ad [4];
    logic [31:0] ex [4];
    logic [31:0] rd;
    logic        er;
    ad = '{8'h0C, 8'h10, 8'h14, 8'h08};
    ex = '{32'h3, 32'h2, 32'h6, 32'h0};
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ad[i], 32'h0, rd, er);
      chk("reg_reset", ex[i], rd);
    end
    apb(1'b0, 8'h20, 32'h0, rd, er);
    chk("unmapped_err", 32'h1, er);
    chk("tx_stat_empty", 32'hC, tx_stat);
    chk("rx_stat_empty", 32'hC, rx_stat);
    $display("test regs done");
  endtask

  // Transmit reset empties a part-filled fifo
  task automatic t_tx_reset;
    logic [31:0] rd;
    logic        er;
    apb(1'b1, 8'h0C, 32'h2, rd, er);
    mac_model_inst.send_frame(1, -1);
    chk("tx_stat_four", 32'h0, tx_stat);
    @(posedge clk);
    tx_rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk("tx_stat_reset", 32'hC, tx_stat);
    tx_rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    $display("test tx reset done");
  endtask

  // Framed packet with one error byte, then interrupt
  task automatic t_tx_frame;
    logic [8:0]  ex [7];
    logic [31:0] rd;
    logic        er;
    ex = '{9'h1FB, 9'h010, 9'h1FE, 9'h012, 9'h013, 9'h1FD, 9'h1F7};
    mac_model_inst.send_frame(4, 1);
    chk("tx_stat_seven", 32'h1, tx_stat);
    ltx_q.delete();
    apb(1'b1, 8'h0C, 32'h3, rd, er);
    repeat (60) @(posedge clk);
    chk("ltx_count", 32'h7, ltx_q.size());
    for (int i = 0; i < 7; i++) chk("ltx_entry", ex[i], ltx_q[i]);
    apb(1'b0, 8'h00, 32'h0, rd, er);
    chk("irq_status", 32'h8, rd);
    chk("irq_masked", 32'h0, irq);
    apb(1'b1, 8'h08, 32'h8, rd, er);
    repeat (2) @(posedge clk);
    chk("irq_on", 32'h1, irq);
    apb(1'b1, 8'h04, 32'h8, rd, er);
    repeat (2) @(posedge clk);
    chk("irq_cleared", 32'h0, irq);
    $display("test tx frame done");
  endtask

  // Receive path: held without sync, then popped per clock
  task automatic t_rx_frame;
    logic [8:0] en [5];
    logic [9:0] ex [6];
    logic [31:0] rd;
    logic        er;
    en = '{9'h1FB, 9'h0A5, 9'h1FE, 9'h03C, 9'h1FD};
    ex = '{10'h2FB, 10'h2A5, 10'h30E, 10'h23C, 10'h000, 10'h000};
    for (int i = 0; i < 5; i++) push(en[i]);
    repeat (10) @(posedge clk);
    chk("rx_stat_five", 32'h0, rx_stat);
    chk("rx_nosync", 32'hFF, rx_data);
    @(posedge rx_clk);
    repeat (5) @(posedge clk);
    lsync <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(posedge rx_clk);
      repeat (6) @(posedge clk);
      chk("rx_out", ex[i], {rx_dv, rx_er, rx_data});
    end
    chk("rx_stat_drained", 32'hC, rx_stat);
    // Without sync nothing pops: fill past full
    lsync <= 1'b0;
    for (int i = 0; i < 9; i++) push(9'(8'h40 + i));
    repeat (2) @(posedge clk);
    chk("rx_stat_full", 32'h3, rx_stat);
    apb(1'b0, 8'h00, 32'h0, rd, er);
    chk("irq_rx_ovf", 32'h2, rd);
    // Receive reset in mid-run empties the fifo
    rx_rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk("rx_stat_reset", 32'hC, rx_stat);
    chk("rx_data_reset", 32'h00, rx_data);
    rx_rst_n <= 1'b1;
    repeat (2) @(posedge rx_clk);
    repeat (6) @(posedge clk);
    chk("rx_resync_high", 32'hFF, rx_data);
    $display("test rx frame done");
  endtask

  // Counts and verdict
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    chk("rx_in_reset", 32'h00, rx_data);
    rst      <= 1'b0;
    tx_rst_n <= 1'b1;
    rx_rst_n <= 1'b1;
    repeat (2) @(posedge rx_clk);
    repeat (6) @(posedge clk);
    chk("rx_after_reset", 32'hFF, rx_data);
    t_regs();
    t_tx_reset();
    t_tx_frame();
    t_rx_frame();
    report_and_stop();
  end
endmodule
